// ==== dbl_defines.vh ====
`ifndef DBL_DEFINES_VH
`define DBL_DEFINES_VH

// Address line codes (addr1, addr0) for the nibble latches.
`define DBL_SEL_LOWMID    2'b00
`define DBL_SEL_LOW       2'b10
`define DBL_SEL_MID       2'b01
`define DBL_SEL_HIGH      2'b11

// Host command codes.
`define DBL_MODE_NIBBLE   2'b00
`define DBL_MODE_BYTE     2'b01
`define DBL_MODE_TRANSP   2'b10

// Bit positions of the fields inside the 12-bit word.
`define DBL_LOW_LSB       0
`define DBL_MID_LSB       4
`define DBL_HIGH_LSB      8

// Timing: strobe widths and the load hold after write release, in ns.
`define DBL_CLK_PERIOD_NS 25
`define DBL_STROBE_NS     50
`define DBL_LDHOLD_NS     50
`define DBL_SETUP_NS      25

`endif

// ==== dbl_pulse_timer.v ====
`timescale 1ns/1ps
`include "dbl_defines.vh"

// Counts a programmed number of cycles and flags completion.
module dbl_pulse_timer #(
    parameter WIDTH = 4
) (
    // Clock and reset.
    input  wire             sys_clk,
    input  wire             rst_n,
    // Control.
    input  wire             start,
    input  wire [WIDTH-1:0] count,
    // Status.
    output reg              done
);

    reg [WIDTH-1:0] cnt_q;

    // ****************************************
    // Down counter
    // ****************************************
    // Done pulses for one cycle once the loaded count has run out.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= {WIDTH{1'b0}};
            done  <= 1'b0;
        end else if (start) begin
            cnt_q <= count;
            done  <= 1'b0;
        end else if (cnt_q != {WIDTH{1'b0}}) begin
            cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
            done  <= (cnt_q == {{(WIDTH-1){1'b0}}, 1'b1});
        end else begin
            done  <= 1'b0;
        end
    end

endmodule // dbl_pulse_timer

// ==== dbl_host.v ====
`timescale 1ns/1ps
`include "dbl_defines.vh"

// Summary of operation
// [RULE1] Device zeros its DAC latch at power-up.
// [RULE2] Low clear zeros DAC latch, ignores select.
// [RULE3] Address, write, select pick target input latches.
// [RULE4] Low enable takes sub-LSBs and two lowest bits.
// [RULE5] Middle enable takes data bits two to five.
// [RULE6] High enable takes data bits six to nine.
// [RULE7] Both address lines low loads low+middle only.
// [RULE8] All twelve DAC latch bits update together.
// [RULE9] DAC latch captures on load rising edge.
// [RULE10] Load held low makes DAC latch transparent.
// [RULE11] Load strobe is asynchronous to write strobe.
// [RULE12] Load low at write release stays 50 ns.
// [RULE13] Input latch is twelve bits wide.
// [RULE14] Host writes zeros into both sub-LSBs.
// [RULE15] Eight data pins, 4+4+4 or 8+4 loading.
// [RULE16] 4-bit host shares low pins with bits 2-5.
// [RULE17] 4-bit host strobes three times per word.
// [RULE18] 8-bit host drives sub-LSBs and bits 0-5.
// [RULE19] Byte and high nibble in any order.
// [RULE20] Fastest: tied address, two write cycles.
// [RULE21] Transparent scheme writes byte before high nibble.
// [RULE22] Address decode of the four nibble selections.
// [RULE23] Latch loads only while write and select low.
// [RULE24] Load low transfers input latch independently.
// [RULE25] Clear low holds DAC latch zero regardless.
module dbl_host #(
    parameter STROBE_CYC = (`DBL_STROBE_NS + `DBL_CLK_PERIOD_NS - 1)
                           / `DBL_CLK_PERIOD_NS,
    parameter LDHOLD_CYC = (`DBL_LDHOLD_NS + `DBL_CLK_PERIOD_NS - 1)
                           / `DBL_CLK_PERIOD_NS,
    parameter SETUP_CYC  = (`DBL_SETUP_NS + `DBL_CLK_PERIOD_NS - 1)
                           / `DBL_CLK_PERIOD_NS
) (
    // Clock and reset.
    input  wire       sys_clk,
    input  wire       rst_n,
    // User command port.
    input  wire       cmdValid,
    input  wire [1:0] cmdMode,
    input  wire       cmdHighFirst,
    input  wire [9:0] cmdData,
    input  wire       cmdClear,
    output reg        cmdReady,
    output reg        cmdDone,
    // Converter pins.
    output reg  [7:0] dataPins,
    output reg        nibble_addr0,
    output reg        nibble_addr1,
    output reg        chip_select_n,
    output reg        write_strobe_n,
    output reg        dac_load_n,
    output reg        clear_n
);

    localparam ST_IDLE  = 3'd0;
    localparam ST_SETUP = 3'd1;
    localparam ST_WRITE = 3'd2;
    localparam ST_GAP   = 3'd3;
    localparam ST_LOAD  = 3'd4;
    localparam ST_HOLD  = 3'd5;

    reg  [2:0]  state_q;
    reg  [1:0]  step_q;
    reg  [1:0]  nSteps_q;
    reg  [11:0] word_q;
    reg  [1:0]  mode_q;
    reg         hiFirst_q;
    reg         tStart_q;
    reg  [3:0]  tCount_q;
    reg  [1:0]  sel_d;
    reg  [7:0]  bus_d;
    wire        tDone;

    dbl_pulse_timer #(
        .WIDTH (4)
    ) u_timer (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .start   (tStart_q),
        .count   (tCount_q),
        .done    (tDone)
    );

    // ****************************************
    // Select and bus value for the current write step
    // ****************************************
    // Byte mode packs sub-LSBs plus bits 0-5 into one write, nibble
    // mode repeats each nibble on both halves of the bus so a 4-bit
    // bus wired in parallel sees valid data either way.
    always @* begin
        sel_d = `DBL_SEL_HIGH;
        bus_d = {word_q[11:8], word_q[11:8]};                // [RULE6]
        if (mode_q == `DBL_MODE_NIBBLE) begin
            case (step_q)
                2'd0: begin
                    sel_d = `DBL_SEL_LOW;                    // [RULE22]
                    bus_d = {word_q[3:0], word_q[3:0]};      // [RULE4] [RULE16]
                end
                2'd1: begin
                    sel_d = `DBL_SEL_MID;
                    bus_d = {word_q[7:4], word_q[7:4]};      // [RULE5]
                end
                default: begin
                    sel_d = `DBL_SEL_HIGH;
                end
            endcase
        // Transparent loads ignore the high-first request: the byte must
        // land first or the converter would briefly show a stale low half.
        end else if ((mode_q == `DBL_MODE_TRANSP) ? (step_q == 2'd0) :
                     ((step_q == 2'd0) != hiFirst_q)) begin
            sel_d = `DBL_SEL_LOWMID;                         // [RULE7] [RULE18]
            bus_d = word_q[7:0];                             // [RULE21]
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    // Every pin comes from a flop; the load strobe is only released
    // after the hold count so a late load still meets its width.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q        <= ST_IDLE;
            step_q         <= 2'd0;
            nSteps_q       <= 2'd0;
            word_q         <= 12'h000;
            mode_q         <= `DBL_MODE_NIBBLE;
            hiFirst_q      <= 1'b0;
            tStart_q       <= 1'b0;
            tCount_q       <= 4'h0;
            cmdReady       <= 1'b0;
            cmdDone        <= 1'b0;
            dataPins       <= 8'h00;
            nibble_addr0   <= 1'b0;
            nibble_addr1   <= 1'b0;
            chip_select_n  <= 1'b1;
            write_strobe_n <= 1'b1;
            dac_load_n     <= 1'b1;
            clear_n        <= 1'b0;                          // [RULE2]
        end else begin
            tStart_q <= 1'b0;
            cmdDone  <= 1'b0;
            clear_n  <= ~cmdClear;                           // [RULE25]
            case (state_q)
                ST_IDLE: begin
                    cmdReady <= 1'b1;
                    if (cmdValid && cmdReady) begin
                        cmdReady  <= 1'b0;
                        word_q    <= {cmdData, 2'b00};       // [RULE13] [RULE14]
                        mode_q    <= cmdMode;
                        hiFirst_q <= cmdHighFirst;           // [RULE19]
                        step_q    <= 2'd0;
                        nSteps_q  <= (cmdMode == `DBL_MODE_NIBBLE) ?
                                     2'd2 : 2'd1;            // [RULE15] [RULE17] [RULE20]
                        dac_load_n <= (cmdMode != `DBL_MODE_TRANSP); // [RULE10]
                        tCount_q  <= SETUP_CYC[3:0];
                        tStart_q  <= 1'b1;
                        state_q   <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    {nibble_addr1, nibble_addr0} <= sel_d;   // [RULE3]
                    dataPins <= bus_d;
                    chip_select_n <= 1'b0;
                    if (tDone) begin
                        write_strobe_n <= 1'b0;              // [RULE23]
                        tCount_q <= STROBE_CYC[3:0];
                        tStart_q <= 1'b1;
                        state_q  <= ST_WRITE;
                    end
                end
                ST_WRITE: begin
                    if (tDone) begin
                        write_strobe_n <= 1'b1;
                        tCount_q <= SETUP_CYC[3:0];
                        tStart_q <= 1'b1;
                        state_q  <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    chip_select_n <= 1'b1;
                    if (tDone) begin
                        if (step_q != nSteps_q) begin
                            step_q   <= step_q + 2'd1;
                            tCount_q <= SETUP_CYC[3:0];
                            tStart_q <= 1'b1;
                            state_q  <= ST_SETUP;
                        end else begin
                            dac_load_n <= 1'b0;              // [RULE8] [RULE24]
                            tCount_q <= LDHOLD_CYC[3:0];
                            tStart_q <= 1'b1;
                            state_q  <= ST_LOAD;
                        end
                    end
                end
                ST_LOAD: begin
                    // Held low at least the hold time past write release.
                    if (tDone) begin
                        dac_load_n <= 1'b1;                  // [RULE9] [RULE12]
                        state_q    <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    cmdDone <= 1'b1;
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // dbl_host

// ==== dbl_host_monitor.sv ====
`timescale 1ns/1ps
// ********
// Pin checker.
// ********
module dbl_host_monitor (
    // Clock and reset.
    input wire       sys_clk,
    input wire       rst_n,
    // User side.
    input wire       cmdValid,
    input wire       cmdClear,
    input wire       cmdReady,
    input wire       cmdDone,
    // Converter pins.
    input wire [7:0] dataPins,
    input wire       nibble_addr0,
    input wire       nibble_addr1,
    input wire       chip_select_n,
    input wire       write_strobe_n,
    input wire       dac_load_n,
    input wire       clear_n
);
    reg  byteSeen_q;
    wire wrOn   = !chip_select_n && !write_strobe_n;
    wire byteWr = wrOn && !nibble_addr0 && !nibble_addr1;
    wire highWr = wrOn && nibble_addr0 && nibble_addr1;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Remembers a byte write so a later high nibble can be judged.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) byteSeen_q <= 1'b0;
        else if (cmdDone) byteSeen_q <= 1'b0;
        else if (byteWr) byteSeen_q <= 1'b1;
    end
    clear_follow_a: assert property ($past(rst_n) |->
        clear_n == !$past(cmdClear)) else $error("clear pin lag");
    sub_lsb_zero_a: assert property (byteWr |->
        dataPins[1:0] == 2'b00) else $error("sub-LSB not zero");
    write_select_a: assert property (!write_strobe_n |->
        !chip_select_n) else $error("write without select");
    write_stable_a: assert property (wrOn && $past(wrOn) |->
        $stable(dataPins) && $stable({nibble_addr1, nibble_addr0}))
        else $error("pins moved in write");
    strobe_width_a: assert property ($fell(write_strobe_n) |->
        !write_strobe_n[*4] ##1 write_strobe_n) else $error("strobe width");
    load_hold_a: assert property ($rose(write_strobe_n) &&
        !dac_load_n |-> ##1 !dac_load_n ##1 !dac_load_n)
        else $error("load hold short");
    done_idle_a: assert property (cmdDone |-> dac_load_n &&
        write_strobe_n && chip_select_n) else $error("done while busy");
    high_order_a: assert property (highWr && !dac_load_n |->
        byteSeen_q) else $error("high nibble before byte");
    take_once_a: assert property (cmdValid && cmdReady |=>
        !cmdReady) else $error("ready after take");
endmodule // dbl_host_monitor
bind dbl_host dbl_host_monitor u_mon (.sys_clk(sys_clk), .rst_n(rst_n),
    .cmdValid(cmdValid), .cmdClear(cmdClear), .cmdReady(cmdReady),
    .cmdDone(cmdDone), .dataPins(dataPins), .nibble_addr0(nibble_addr0),
    .nibble_addr1(nibble_addr1), .chip_select_n(chip_select_n),
    .write_strobe_n(write_strobe_n), .dac_load_n(dac_load_n),
    .clear_n(clear_n));

// ==== dbl_dac_model.sv ====
`timescale 1ns/1ps
// ********
// Behavioural converter front end.
// ********
module dbl_dac_model (
    // Converter pins.
    input wire [7:0]  dataPins,
    input wire        nibble_addr0,
    input wire        nibble_addr1,
    input wire        chip_select_n,
    input wire        write_strobe_n,
    input wire        dac_load_n,
    input wire        clear_n,
    // Latched code.
    output reg [11:0] dacLatch
);
    reg [11:0] inLatch;
    // Power comes up with a zero code.
    initial begin
        inLatch = 12'h000;
        dacLatch = 12'h000;
    end
    // Level latches, so a late strobe edge still lands the data.
    always @* begin
        if (!chip_select_n && !write_strobe_n) begin
            case ({nibble_addr1, nibble_addr0})
                2'b00: inLatch[7:0] = dataPins;
                2'b10: inLatch[3:0] = dataPins[3:0];
                2'b01: inLatch[7:4] = dataPins[7:4];
                default: inLatch[11:8] = dataPins[3:0];
            endcase
        end
    end
    // Clear wins; the load strobe is taken as a pure level.
    always @* begin
        if (!clear_n) dacLatch = 12'h000;
        else if (!dac_load_n) dacLatch = inLatch;
    end
endmodule // dbl_dac_model

// ==== dac_double_buffered_parallel_load_tb_top.sv ====
`timescale 1ns/1ps
`include "dbl_defines.vh"
// ********
// Host bench.
// ********
module dac_double_buffered_parallel_load_tb_top;
    reg        sys_clk = 1'b0;
    reg        rst_n = 1'b0;
    reg        cmdValid = 1'b0;
    reg  [1:0] cmdMode = 2'b00;
    reg        cmdHighFirst = 1'b0;
    reg  [9:0] cmdData = 10'h000;
    reg        cmdClear = 1'b0;
    wire       cmdReady, cmdDone, addrBit0, addrBit1, csN, wrN, ldN, clearN;
    wire [7:0] pins;
    wire [11:0] dac;
    int        err_total = 0;
    int        checks_done = 0;
    always #12.5 sys_clk = ~sys_clk;
    dbl_host u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .cmdValid(cmdValid),
        .cmdMode(cmdMode), .cmdHighFirst(cmdHighFirst), .cmdData(cmdData),
        .cmdClear(cmdClear), .cmdReady(cmdReady), .cmdDone(cmdDone),
        .dataPins(pins), .nibble_addr0(addrBit0), .nibble_addr1(addrBit1),
        .chip_select_n(csN), .write_strobe_n(wrN), .dac_load_n(ldN),
        .clear_n(clearN));
    dbl_dac_model u_dev (.dataPins(pins), .nibble_addr0(addrBit0),
        .nibble_addr1(addrBit1), .chip_select_n(csN), .write_strobe_n(wrN),
        .dac_load_n(ldN), .clear_n(clearN), .dacLatch(dac));
    task chk(input string nm, input [11:0] exp, input [11:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task close_out;
        $display("errors %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // One whole transfer; the old code must stand until the load strobe.
    task send(input [1:0] m, input hf, input [9:0] d);
        int n;
        bit ld;
        reg [11:0] old;
        old = dac;
        n = 0;
        ld = 0;
        cmdMode <= m;
        cmdHighFirst <= hf;
        cmdData <= d;
        cmdValid <= 1'b1;
        do @(posedge sys_clk); while (cmdReady !== 1'b1);
        cmdValid <= 1'b0;
        while (cmdDone !== 1'b1 && n < 200) begin
            @(posedge sys_clk);
            n++;
            if (ldN !== 1'b1) ld = 1;
            if (m != `DBL_MODE_TRANSP && !ld) chk("held", old, dac);
        end
        if (n == 200) chk("done", 12'h001, 12'h000);
        chk("word", cmdClear ? 12'h000 : {d, 2'b00}, dac);
    endtask
    task t_modes;
        reg [9:0] v [3];
        v = '{10'h3ff, 10'h000, 10'h155};
        for (int m = 0; m < 3; m++)
            for (int i = 0; i < 3; i++)
                send(m[1:0], 1'b0, v[i]);
    endtask
    task t_order;
        send(`DBL_MODE_BYTE, 1'b1, 10'h26a);
        send(`DBL_MODE_BYTE, 1'b1, 10'h195);
        send(`DBL_MODE_TRANSP, 1'b1, 10'h0f5);
    endtask
    // Clear must win over loads and leave a zero code behind it.
    task t_clear;
        cmdClear <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk("clear", 12'h000, dac);
        send(`DBL_MODE_BYTE, 1'b0, 10'h3c3);
        cmdClear <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk("after", 12'h000, dac);
        send(`DBL_MODE_TRANSP, 1'b0, 10'h200);
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        chk("power", 12'h000, dac);
        t_modes();
        t_order();
        t_clear();
        close_out();
    end
    // Cuts a hang short at several times the expected run length.
    initial begin
        #100000;
        err_total++;
        close_out();
    end
endmodule // dac_double_buffered_parallel_load_tb_top
